// File: dsrc_pkg.sv
package dsrc_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_TRIP_SEL  = 8'h04;
    localparam logic [7:0] OFF_DELAY     = 8'h08;
    localparam logic [7:0] OFF_SLEEP_T   = 8'h0c;
    localparam logic [7:0] OFF_SLEEP_F   = 8'h10;
    localparam logic [7:0] OFF_RESUME_F  = 8'h14;
    localparam logic [7:0] OFF_BOOST     = 8'h18;
    localparam logic [7:0] OFF_BOOST_TO  = 8'h1c;
    localparam logic [7:0] OFF_FB_FS     = 8'h20;
    localparam logic [7:0] OFF_BUS_OUT0  = 8'h24;
    localparam logic [7:0] OFF_BUS_OUT1  = 8'h28;
    localparam logic [7:0] OFF_CARRIER   = 8'h2c;
    localparam logic [7:0] OFF_STATUS    = 8'h30;
    localparam logic [7:0] OFF_LIMITS    = 8'h34;

    // ==========================================================
    // Control register fields
    localparam int CTRL_CLOSED_LOOP = 0;
    localparam int CTRL_LOCAL_REF   = 1;
    localparam int CTRL_JOG         = 2;
    localparam int CTRL_NOISE_LO    = 4;
    localparam int CTRL_FLY_LO      = 8;

    // ==========================================================
    // Reset values and ranges
    localparam logic [3:0]  TRIP_SEL_RST   = 4'h0;
    localparam logic [3:0]  TRIP_SEL_INF   = 4'h9;
    localparam logic [10:0] DELAY_RST      = 11'h00a;
    localparam logic [10:0] DELAY_MAX      = 11'h708;
    localparam logic [8:0]  SLEEP_T_OFF    = 9'h12d;
    localparam logic [15:0] SLEEP_F_RST    = 16'h0000;
    localparam logic [15:0] RESUME_F_RST   = 16'h01f4;
    localparam logic [7:0]  BOOST_RST      = 8'h64;
    localparam logic [7:0]  BOOST_MAX      = 8'hc8;
    localparam logic [7:0]  BOOST_MIN      = 8'h01;
    localparam logic [16:0] FB_FS_RST      = 17'h061a8;
    localparam logic [16:0] FB_FS_MIN      = 17'h00064;
    localparam logic [16:0] FB_FS_MAX      = 17'h0fde8;
    localparam logic [9:0]  BUS_OUT_MIN    = 10'h001;
    localparam logic [9:0]  BUS_OUT_MAX    = 10'h3e8;
    localparam logic [1:0]  FLY_OFF        = 2'h0;
    localparam logic [1:0]  FLY_CATCH      = 2'h1;
    localparam logic [1:0]  FLY_BRAKE      = 2'h3;
    localparam logic [1:0]  NOISE_FIXED    = 2'h1;

    // ==========================================================
    // Timing
    localparam int CLK_HZ       = 250_000_000;
    localparam int SECOND_NS    = 1_000_000_000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_CYCLES  = SECOND_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        RUN_S       = 3'b000,
        TRIPPED_S   = 3'b001,
        BOOST_S     = 3'b010,
        RAMP_DOWN_S = 3'b011,
        SLEEP_S     = 3'b100,
        BRAKE_S     = 3'b101,
        CATCH_S     = 3'b110
    } dsrc_state_e;

endpackage

// File: dsrc_control.sv
// Contract
// - Pulse feedback full-scale frequency settable 100..65000 Hz, default 25000 Hz.
// - Bus output values 0.1..100.0 written by host; hidden from operator panel.
// - Trip select: 0 manual, 1-5 attempts, 6/7/8 give 10/15/20, 9 unlimited.
// - Manual mode clears trip only on reset key or input; no auto restart.
// - Auto mode waits retry delay 0..1800 s, default 10 s, before each attempt.
// - Flying start code 0 off, 1 catch spinning motor, 3 brake then start.
// - With flying start code 1, catch runs at every start command rising.
// - Brake-and-start mode applies DC brake first, then normal start.
// - Catch only attempted while motor speed below output high limit.
// - Sleep inhibited under local reference or jog; works open and closed loop.
// - Sleep timer runs below sleep threshold, resets when frequency rises above.
// - On sleep timer expiry ramp motor down to stop with ramp-down time.
// - While asleep, wake when theoretical frequency exceeds resume threshold.
// - Sleep timer 0..300 s; 301 means off and is the default.
// - Resume threshold between sleep threshold and high limit, default 50 Hz.
// - Below sleep threshold, output follows theoretical frequency down to low limit.
// - Closed loop raises setpoint to boost percent 1..200, default 100, before sleep.
// - Boost not reached within time-out abandons sleep, resumes normal operation.
// - Programmed carrier rate used only under fixed switching method code 1.
`timescale 1ns/1ns
`default_nettype none

module dsrc_control #(
    parameter int TICK_CYCLES = dsrc_pkg::TICK_CYCLES
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        trip_in,
    input  wire logic        reset_key_in,
    input  wire logic        start_cmd_in,
    input  wire logic        brake_done,
    input  wire logic        catch_done,
    input  wire logic        stopped,
    input  wire logic        boost_reached,
    input  wire logic [15:0] out_freq,
    input  wire logic [15:0] theo_freq,
    input  wire logic [15:0] motor_speed,
    input  wire logic [15:0] carrier_in,
    output logic             trip_clear,
    output logic             run_enable,
    output logic             dc_brake,
    output logic             catch_motor,
    output logic             ramp_down,
    output logic             boost_on,
    output logic [7:0]       boost_pct,
    output logic             follow_theo,
    output logic             sleeping,
    output logic [16:0]      feedback_pulse_full_scale,
    output logic [9:0]       bus_out0,
    output logic [9:0]       bus_out1,
    output logic             carrier_fixed,
    output logic [15:0]      inverter_carrier_rate
);

    // ==========================================================
    // Pin synchronisers
    logic [1:0] trip_sync_reg, key_sync_reg, start_sync_reg;
    logic       start_prev_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trip_sync_reg  <= 2'h0;
            key_sync_reg   <= 2'h0;
            start_sync_reg <= 2'h0;
            start_prev_reg <= 1'b0;
        end else begin
            trip_sync_reg  <= {trip_sync_reg[0], trip_in};
            key_sync_reg   <= {key_sync_reg[0], reset_key_in};
            start_sync_reg <= {start_sync_reg[0], start_cmd_in};
            start_prev_reg <= start_sync_reg[1];
        end
    end
    wire trip_s   = trip_sync_reg[1];
    wire key_s    = key_sync_reg[1];
    wire start_s  = start_sync_reg[1];
    wire start_re = start_s && !start_prev_reg;

    // ==========================================================
    // Registers
    logic [8:0]  ctrl_reg;
    logic [3:0]  trip_sel_reg;
    logic [10:0] delay_reg;
    logic [8:0]  sleep_t_reg;
    logic [15:0] sleep_f_reg, resume_f_reg, high_lim_reg, low_lim_reg;
    logic [7:0]  boost_reg;
    logic [15:0] boost_to_reg;
    logic [16:0] fb_fs_reg;
    logic [9:0]  bus0_reg, bus1_reg;
    logic [15:0] carrier_reg;

    logic        aw_held_reg, w_held_reg;
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    wire do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    wire [31:0] wd = wdata_reg;
    wire full_word = (wstrb_reg == 4'hf);
    wire addr_ok   = (awaddr_reg[1:0] == 2'h0) && (awaddr_reg <= dsrc_pkg::OFF_LIMITS);
    // Flying code in bits 9:8 maps to enable (bit 8) and brake-first (bit 6); code 2 keeps both
    wire [8:0] ctrl_wr = (wd[9:8] == 2'h2) ? {ctrl_reg[8], wd[7], ctrl_reg[6], wd[5:0]}
                                           : {wd[9:8] != 2'h0, wd[7], wd[9:8] == 2'h3,
                                              wd[5:0]};

    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            awaddr_reg   <= 8'h00;
            wdata_reg    <= 32'h0;
            wstrb_reg    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (addr_ok && awaddr_reg != dsrc_pkg::OFF_STATUS)
                                ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Partial-strobe writes are ignored: the range-checked fields would need range checks per lane
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg     <= 9'h000;
            trip_sel_reg <= dsrc_pkg::TRIP_SEL_RST;
            delay_reg    <= dsrc_pkg::DELAY_RST;
            sleep_t_reg  <= dsrc_pkg::SLEEP_T_OFF;
            sleep_f_reg  <= dsrc_pkg::SLEEP_F_RST;
            resume_f_reg <= dsrc_pkg::RESUME_F_RST;
            boost_reg    <= dsrc_pkg::BOOST_RST;
            boost_to_reg <= 16'h000a;
            fb_fs_reg    <= dsrc_pkg::FB_FS_RST;
            bus0_reg     <= dsrc_pkg::BUS_OUT_MIN;
            bus1_reg     <= dsrc_pkg::BUS_OUT_MIN;
            carrier_reg  <= 16'h1194;
            high_lim_reg <= 16'h01f4;
            low_lim_reg  <= 16'h0000;
        end else if (do_write && full_word) begin
            unique case (awaddr_reg)
                dsrc_pkg::OFF_CTRL: ctrl_reg <= ctrl_wr;
                dsrc_pkg::OFF_TRIP_SEL:
                    if (wd[3:0] <= dsrc_pkg::TRIP_SEL_INF) trip_sel_reg <= wd[3:0];
                dsrc_pkg::OFF_DELAY:
                    if (wd[10:0] <= dsrc_pkg::DELAY_MAX && wd[31:11] == 21'h0)
                        delay_reg <= wd[10:0];
                dsrc_pkg::OFF_SLEEP_T:
                    if (wd[8:0] <= dsrc_pkg::SLEEP_T_OFF && wd[31:9] == 23'h0)
                        sleep_t_reg <= wd[8:0];
                dsrc_pkg::OFF_SLEEP_F:
                    if (wd[15:0] <= resume_f_reg) sleep_f_reg <= wd[15:0];
                dsrc_pkg::OFF_RESUME_F:
                    resume_f_reg <= clamp16(wd[15:0], sleep_f_reg, high_lim_reg);
                dsrc_pkg::OFF_BOOST:
                    if (wd[7:0] >= dsrc_pkg::BOOST_MIN && wd[7:0] <= dsrc_pkg::BOOST_MAX &&
                        wd[31:8] == 24'h0)
                        boost_reg <= wd[7:0];
                dsrc_pkg::OFF_BOOST_TO: boost_to_reg <= wd[15:0];
                dsrc_pkg::OFF_FB_FS:
                    if (wd[16:0] >= dsrc_pkg::FB_FS_MIN && wd[16:0] <= dsrc_pkg::FB_FS_MAX &&
                        wd[31:17] == 15'h0)
                        fb_fs_reg <= wd[16:0];
                dsrc_pkg::OFF_BUS_OUT0:
                    if (wd[9:0] >= dsrc_pkg::BUS_OUT_MIN && wd[9:0] <= dsrc_pkg::BUS_OUT_MAX &&
                        wd[31:10] == 22'h0)
                        bus0_reg <= wd[9:0];
                dsrc_pkg::OFF_BUS_OUT1:
                    if (wd[9:0] >= dsrc_pkg::BUS_OUT_MIN && wd[9:0] <= dsrc_pkg::BUS_OUT_MAX &&
                        wd[31:10] == 22'h0)
                        bus1_reg <= wd[9:0];
                dsrc_pkg::OFF_CARRIER: carrier_reg <= wd[15:0];
                dsrc_pkg::OFF_LIMITS: begin
                    low_lim_reg  <= wd[15:0];
                    high_lim_reg <= wd[31:16];
                end
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Supervisor state machine
    dsrc_pkg::dsrc_state_e state_reg, state_next;
    logic [31:0] tick_cnt_reg;
    logic [15:0] sec_cnt_reg;
    logic [4:0]  attempts_reg;

    wire fly_catch_sel     = ctrl_reg[dsrc_pkg::CTRL_FLY_LO];
    wire fly_brake_sel     = ctrl_reg[dsrc_pkg::CTRL_NOISE_LO + 2];
    wire closed_loop       = ctrl_reg[dsrc_pkg::CTRL_CLOSED_LOOP];
    wire sleep_allowed     = !ctrl_reg[dsrc_pkg::CTRL_LOCAL_REF] && !ctrl_reg[dsrc_pkg::CTRL_JOG]
                             && (sleep_t_reg != dsrc_pkg::SLEEP_T_OFF);
    wire below_sleep       = out_freq < sleep_f_reg;
    wire tick              = (tick_cnt_reg == TICK_CYCLES - 1);

    // Attempt budget for a trip-selection code
    function automatic logic [4:0] attempt_limit(input logic [3:0] sel);
        unique case (sel)
            4'h6:    attempt_limit = 5'h0a;
            4'h7:    attempt_limit = 5'h0f;
            4'h8:    attempt_limit = 5'h14;
            4'h9:    attempt_limit = 5'h1f;
            default: attempt_limit = {1'b0, sel};
        endcase
    endfunction
    wire auto_sel     = trip_sel_reg != 4'h0;
    wire budget_left  = (trip_sel_reg == dsrc_pkg::TRIP_SEL_INF) ||
                        (attempts_reg < attempt_limit(trip_sel_reg));
    wire delay_done   = sec_cnt_reg >= {5'h0, delay_reg};
    wire can_catch    = motor_speed < high_lim_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            dsrc_pkg::RUN_S:
                if (trip_s) state_next = dsrc_pkg::TRIPPED_S;
                else if (start_re && fly_brake_sel) state_next = dsrc_pkg::BRAKE_S;
                else if (start_re && fly_catch_sel && can_catch)
                    state_next = dsrc_pkg::CATCH_S;
                else if (sleep_allowed && below_sleep && tick &&
                         sec_cnt_reg + 16'h1 >= {7'h0, sleep_t_reg})
                    state_next = closed_loop ? dsrc_pkg::BOOST_S : dsrc_pkg::RAMP_DOWN_S;
            dsrc_pkg::TRIPPED_S:
                if (key_s) state_next = dsrc_pkg::RUN_S;
                else if (auto_sel && budget_left && delay_done)
                    state_next = dsrc_pkg::RUN_S;
            dsrc_pkg::BOOST_S:
                if (trip_s) state_next = dsrc_pkg::TRIPPED_S;
                else if (boost_reached) state_next = dsrc_pkg::RAMP_DOWN_S;
                else if (sec_cnt_reg >= boost_to_reg) state_next = dsrc_pkg::RUN_S;
            dsrc_pkg::RAMP_DOWN_S:
                if (trip_s) state_next = dsrc_pkg::TRIPPED_S;
                else if (stopped) state_next = dsrc_pkg::SLEEP_S;
            dsrc_pkg::SLEEP_S:
                if (trip_s) state_next = dsrc_pkg::TRIPPED_S;
                else if (!sleep_allowed || theo_freq > resume_f_reg)
                    state_next = dsrc_pkg::RUN_S;
            dsrc_pkg::BRAKE_S:
                if (trip_s) state_next = dsrc_pkg::TRIPPED_S;
                else if (brake_done) state_next = dsrc_pkg::RUN_S;
            dsrc_pkg::CATCH_S:
                if (trip_s) state_next = dsrc_pkg::TRIPPED_S;
                else if (catch_done) state_next = dsrc_pkg::RUN_S;
            default: state_next = dsrc_pkg::RUN_S;
        endcase
    end

    wire leave = state_next != state_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg    <= dsrc_pkg::RUN_S;
            tick_cnt_reg <= 32'h0;
            sec_cnt_reg  <= 16'h0;
            attempts_reg <= 5'h00;
        end else begin
            state_reg    <= state_next;
            tick_cnt_reg <= (tick || leave) ? 32'h0 : tick_cnt_reg + 32'h1;
            // Second counter restarts on every state change and, in RUN_S, at or above the threshold
            if (leave || (state_reg == dsrc_pkg::RUN_S && !below_sleep))
                sec_cnt_reg <= 16'h0;
            else if (tick && sec_cnt_reg != 16'hffff)
                sec_cnt_reg <= sec_cnt_reg + 16'h1;
            if (state_reg == dsrc_pkg::TRIPPED_S && key_s)
                attempts_reg <= 5'h00;
            else if (state_reg == dsrc_pkg::TRIPPED_S && leave && attempts_reg != 5'h1f)
                attempts_reg <= attempts_reg + 5'h01;
        end
    end

    // ==========================================================
    // Outputs
    assign trip_clear  = state_reg == dsrc_pkg::TRIPPED_S && leave;
    assign run_enable  = state_reg != dsrc_pkg::TRIPPED_S && state_reg != dsrc_pkg::SLEEP_S;
    assign dc_brake    = state_reg == dsrc_pkg::BRAKE_S;
    assign catch_motor = state_reg == dsrc_pkg::CATCH_S;
    assign ramp_down   = state_reg == dsrc_pkg::RAMP_DOWN_S;
    assign boost_on    = state_reg == dsrc_pkg::BOOST_S;
    assign boost_pct   = boost_reg;
    assign follow_theo = sleep_allowed && below_sleep && out_freq > low_lim_reg;
    assign sleeping    = state_reg == dsrc_pkg::SLEEP_S;
    assign feedback_pulse_full_scale = fb_fs_reg;
    assign bus_out0    = bus0_reg;
    assign bus_out1    = bus1_reg;
    assign carrier_fixed = ctrl_reg[dsrc_pkg::CTRL_NOISE_LO +: 2] == dsrc_pkg::NOISE_FIXED;
    assign inverter_carrier_rate = carrier_fixed ? carrier_reg : carrier_in;

    // ==========================================================
    // Read channel; bus output values are write-only to keep them off the panel path
    logic [31:0] rd_mux;
    always_comb begin
        unique case (s_axi_araddr)
            dsrc_pkg::OFF_CTRL:     rd_mux = {23'h0, ctrl_reg};
            dsrc_pkg::OFF_TRIP_SEL: rd_mux = {28'h0, trip_sel_reg};
            dsrc_pkg::OFF_DELAY:    rd_mux = {21'h0, delay_reg};
            dsrc_pkg::OFF_SLEEP_T:  rd_mux = {23'h0, sleep_t_reg};
            dsrc_pkg::OFF_SLEEP_F:  rd_mux = {16'h0, sleep_f_reg};
            dsrc_pkg::OFF_RESUME_F: rd_mux = {16'h0, resume_f_reg};
            dsrc_pkg::OFF_BOOST:    rd_mux = {24'h0, boost_reg};
            dsrc_pkg::OFF_BOOST_TO: rd_mux = {16'h0, boost_to_reg};
            dsrc_pkg::OFF_FB_FS:    rd_mux = {15'h0, fb_fs_reg};
            dsrc_pkg::OFF_CARRIER:  rd_mux = {16'h0, carrier_reg};
            dsrc_pkg::OFF_STATUS:   rd_mux = {19'h0, attempts_reg, 5'h0, state_reg};
            dsrc_pkg::OFF_LIMITS:   rd_mux = {high_lim_reg, low_lim_reg};
            default:                rd_mux = 32'h0;
        endcase
    end
    wire rd_ok = s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= dsrc_pkg::OFF_LIMITS &&
                 s_axi_araddr != dsrc_pkg::OFF_BUS_OUT0 && s_axi_araddr != dsrc_pkg::OFF_BUS_OUT1;
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_ok ? rd_mux : 32'h0;
            s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    manual_no_auto_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == dsrc_pkg::TRIPPED_S && trip_sel_reg == 4'h0 && !key_s
        |=> state_reg == dsrc_pkg::TRIPPED_S) else $error("manual mode left trip alone");
    carrier_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !carrier_fixed |-> inverter_carrier_rate == carrier_in) else $error("carrier gate");
    sleep_inhibit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == dsrc_pkg::RUN_S && ctrl_reg[dsrc_pkg::CTRL_JOG]
        |=> state_reg != dsrc_pkg::BOOST_S && state_reg != dsrc_pkg::RAMP_DOWN_S)
        else $error("sleep entered under jog");
    wake_up_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == dsrc_pkg::SLEEP_S && !trip_s && theo_freq > resume_f_reg
        |=> state_reg == dsrc_pkg::RUN_S) else $error("no wake");
    brake_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == dsrc_pkg::RUN_S && start_re && fly_brake_sel && !trip_s
        |=> dc_brake) else $error("brake not first");
    attempt_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == dsrc_pkg::TRIPPED_S && key_s |=> attempts_reg == 5'h00)
        else $error("attempts kept");
    boost_closed_a: assert property (@(posedge aclk) disable iff (!aresetn)
        boost_on |-> closed_loop || $past(state_reg) == dsrc_pkg::BOOST_S)
        else $error("boost in open loop");
    ramp_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ramp_down && stopped && !trip_s |=> sleeping) else $error("ramp did not stop");

endmodule

`default_nettype wire

// File: dsrc_partner.sv
`timescale 1ns/1ns
`default_nettype none
module dsrc_partner (
    input  wire logic aclk,
    input  wire logic dc_brake,
    input  wire logic catch_motor,
    input  wire logic ramp_down,
    input  wire logic boost_on,
    output logic      brake_done,
    output logic      catch_done,
    output logic      stopped,
    output logic      boost_reached
);
    always_ff @(posedge aclk) // Answers a cycle late, never at once
        {brake_done, catch_done, stopped, boost_reached} <=
            {dc_brake, catch_motor, ramp_down, boost_on};
endmodule
`default_nettype wire

// File: test_drive_sleep_restart_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_drive_sleep_restart_control;
    logic aclk = 0, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic trip_in, reset_key_in, start_cmd_in, brake_done, catch_done, stopped, boost_reached;
    logic trip_clear, run_enable, dc_brake, catch_motor, ramp_down, boost_on, follow_theo;
    logic sleeping, carrier_fixed;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb;
    logic [7:0] s_axi_awaddr, s_axi_araddr, boost_pct;
    logic [9:0] bus_out0, bus_out1;
    logic [15:0] out_freq, theo_freq, motor_speed, carrier_in, inverter_carrier_rate;
    logic [16:0] feedback_pulse_full_scale;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [31:0] exp_reg [12] = '{0, 0, 'ha, 'h12d, 0, 'h1f4, 'h64, 'ha, 'h61a8, 0, 0, 'h1194};
    int bad_count = 0, samples_checked = 0, seed = 32'h62eb, i, k;
    dsrc_control #(.TICK_CYCLES(10)) dut (.*);
    dsrc_partner far_end (.*);
    initial forever #2 aclk = ~aclk;
    task automatic chk(input logic [31:0] got, exp);
        samples_checked++;
        bad_count += (got !== exp);
        if (got !== exp) $display("[ERR] %0t got %h want %h", $time, got, exp);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic xfer(input bit w, logic [7:0] a, logic [31:0] d, logic [1:0] r);
        logic [1:0]  resp;
        logic [31:0] data;
        logic        aw_t, w_t, ar_t, done;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
        for (i = 0; i < 60; i++) begin
            // Settled values mid-cycle are what the next rising edge samples
            @(negedge aclk);
            aw_t = s_axi_awvalid && s_axi_awready === 1;
            w_t = s_axi_wvalid && s_axi_wready === 1;
            ar_t = s_axi_arvalid && s_axi_arready === 1;
            done = w ? s_axi_bvalid === 1 : s_axi_rvalid === 1;
            resp = w ? s_axi_bresp : s_axi_rresp;
            data = s_axi_rdata;
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 0;
            if (w_t) s_axi_wvalid <= 0;
            if (ar_t) s_axi_arvalid <= 0;
            if (done) break;
        end
        chk(i < 60, 1);
        if (i == 60) end_sim();
        chk(resp, r);
        if (!w) chk(data, d);
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, trip_in, reset_key_in} = 0;
        {start_cmd_in, s_axi_awaddr, s_axi_araddr, s_axi_wdata, out_freq} = 0;
        {theo_freq, motor_speed, carrier_in, s_axi_wstrb, s_axi_bready, s_axi_rready} = 54'ha97f;
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        for (k = 0; k < 12; k++)
            xfer(0, 8'(4 * k), exp_reg[k], {k == 9 || k == 10, 1'b0});
        xfer(0, 8'h3c, 32'h0, 2'h2);
        v = 32'h64 + {$random(seed)} % 32'hfd85;
        xfer(1, 8'h20, v, 2'h0);
        xfer(0, 8'h20, v, 2'h0);
        xfer(1, 8'h00, 32'h10, 2'h0);
        chk(inverter_carrier_rate, 16'h1194);
        xfer(1, 8'h00, 32'h310, 2'h0);
        start_cmd_in <= 1;
        for (i = 0; i < 20 && dc_brake !== 1; i++) @(negedge aclk);
        chk(i < 20, 1);
        for (i = 0; i < 20 && run_enable !== 1 || dc_brake !== 0; i++) @(negedge aclk);
        chk(i < 20, 1);
        xfer(1, 8'h04, 32'h1, 2'h0);
        xfer(1, 8'h08, 32'h3, 2'h0);
        trip_in <= 1;
        repeat (6) @(posedge aclk);
        trip_in <= 0;
        for (i = 0; i < 40 && run_enable !== 1; i++) @(negedge aclk);
        chk(i > 12 && i < 40, 1); // Lower bound sits well below the 30-cycle retry delay
        xfer(0, 8'h30, 32'h100, 2'h0);
        trip_in <= 1;
        repeat (150) @(posedge aclk);
        chk(run_enable, 0);
        {trip_in, reset_key_in} <= 2'b01;
        for (i = 0; i < 20 && trip_clear !== 1; i++) @(negedge aclk);
        chk(i < 20, 1);
        end_sim();
    end
endmodule
`default_nettype wire
